// >>> pps_consts.svh
/*
  Constants for the pump pressure supervisor: clock timing, register word
  indexes, reset values, write masks and parameter limits.
  Assumes inclusion by the design modules and the testbench; pps_pkg.sv does not include it.
*/
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// Timing
`define PPS_CLK_NS        8
`define PPS_TICK_NS       1000000000
`define PPS_TICK_CYCLES   (`PPS_TICK_NS / `PPS_CLK_NS)
`define PPS_SLEEP_DELAY_S 14'h0006

// Register word indexes (byte address = 4 * index)
`define PPS_A_CTRL   4'h0
`define PPS_A_RANGE  4'h1
`define PPS_A_OFFS   4'h2
`define PPS_A_SETP   4'h3
`define PPS_A_SCALE  4'h4
`define PPS_A_SUCT   4'h5
`define PPS_A_CYCLE  4'h6
`define PPS_A_ONTIME 4'h7
`define PPS_A_SLEEP  4'h8
`define PPS_A_CURVE  4'h9
`define PPS_A_STAT   4'ha
`define PPS_A_IRQ    4'hb
`define PPS_A_MASK   4'hc
`define PPS_A_FREQ   4'hd
`define PPS_A_RDG    4'he

// Reset values
`define PPS_RST_CTRL   32'h0000_0000
`define PPS_RST_RANGE  32'h0000_0096
`define PPS_RST_OFFS   32'h0000_0000
`define PPS_RST_SETP   32'h003c_0032
`define PPS_RST_SCALE  32'h0000_0001
`define PPS_RST_SUCT   32'h0000_7800
`define PPS_RST_CYCLE  32'h0000_001e
`define PPS_RST_ONTIME 32'h003c_000f
`define PPS_RST_SLEEP  32'h0003_000f
`define PPS_RST_CURVE  32'h0f1c_0012

// Writable bits
`define PPS_M_CTRL   32'h0000_0003
`define PPS_M_RANGE  32'h0000_01ff
`define PPS_M_OFFS   32'h00ff_ffff
`define PPS_M_SETP   32'h007f_03ff
`define PPS_M_SCALE  32'h0000_000f
`define PPS_M_SUCT   32'h0007_ffff
`define PPS_M_CYCLE  32'h0000_3fff
`define PPS_M_ONTIME 32'h03ff_03ff
`define PPS_M_SLEEP  32'h01ff_03ff
`define PPS_M_CURVE  32'h3ffc_03ff
`define PPS_M_IRQ    4'hf

// Limits
`define PPS_RANGE_MIN  14'h0032
`define PPS_RANGE_MAX  14'h01f4
`define PPS_OFFS_LIM   8'h32
`define PPS_FOFF_LIM   8'h1e
`define PPS_SUCT_MAX   14'h0708
`define PPS_LOW_MAX    14'h00c8
`define PPS_OFF_TIME_THRESHOLD_MAX   14'h270f
`define PPS_ON_MAX     14'h03e8
`define PPS_BAND_MAX   14'h03e8
`define PPS_DET_MIN    14'h0001
`define PPS_DET_MAX    14'h012c
`define PPS_CURVE_MIN  14'h0001
`define PPS_CURVE_MAX  14'h03e7

// Scaling
`define PPS_ADC_SHIFT  12
`define PPS_BAND_SCALE 22'h0003e8
`define PPS_HZ_UNITS   16'h0064

`endif

// >>> pps_pkg.sv
/*
  Types for the pump pressure supervisor: register layouts and states.
  Assumes pps_consts.svh is included alongside for the numeric constants.
*/
package pps_pkg;

  typedef enum logic [1:0] {
    PPS_STOP = 2'b00,
    PPS_RUN  = 2'b01,
    PPS_RAMP = 2'b10,
    PPS_HOLD = 2'b11
  } pps_fsm_t;

  typedef struct packed {
    logic [29:0] rsvd;
    logic        role_sel;
    logic        run_en;
  } pps_ctrl_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic [8:0]  span;
  } pps_range_t;

  typedef struct packed {
    logic [7:0]        rsvd;
    logic signed [7:0] freq_off;
    logic signed [7:0] sp_off;
    logic signed [7:0] meas_off;
  } pps_offs_t;

  typedef struct packed {
    logic [8:0] rsvd;
    logic [6:0] freq_cmd;
    logic [5:0] rsvd2;
    logic [9:0] setpoint;
  } pps_setp_t;

  typedef struct packed {
    logic [27:0] rsvd;
    logic [1:0]  level_mul;
    logic [1:0]  flow_mul;
  } pps_scale_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [7:0]  low_level;
    logic [10:0] suct_time;
  } pps_suct_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic [13:0] off_time_threshold;
  } pps_cycle_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [9:0] long_min_on_time;
    logic [5:0] rsvd2;
    logic [9:0] short_min_on_time;
  } pps_ontime_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic [8:0] detect;
    logic [5:0] rsvd2;
    logic [9:0] band;
  } pps_sleep_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [6:0] min_freq;
    logic [4:0] sleep_freq;
    logic [7:0] rsvd2;
    logic [9:0] curve;
  } pps_curve_t;

  typedef struct packed {
    logic [3:0]         rsvd;
    pps_fsm_t           fsm;
    logic               fault;
    logic               run;
    logic signed [11:0] sp;
    logic signed [11:0] meas;
  } pps_stat_t;

  typedef struct packed {
    logic [15:0] level;
    logic [15:0] flow;
  } pps_rdg_t;

endpackage

// >>> pps_sec_timer.sv
/*
  Seconds counter for one qualifying condition.
  Assumes tick is a one-cycle pulse once per second from the same clock.
*/
`timescale 1ns/100ps
`include "pps_consts.svh"

module pps_sec_timer
  import pps_pkg::*;
#(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Time base and condition
  input  wire logic         tick,
  input  wire logic         qualify,
  input  wire logic [W-1:0] limit,
  // Result
  output logic      [W-1:0] count,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } pps_tmr_t;

  pps_tmr_t s;
  pps_tmr_t next_s;

  // Count whole seconds, saturating, cleared as soon as the condition lapses
  always_comb begin
    next_s = s;
    if (!qualify) begin
      next_s.cnt = '0;
    end else if (tick && s.cnt != '1) begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // A zero limit is met at once while the condition holds
  assign count = s.cnt;
  assign done  = qualify && (s.cnt >= limit);

endmodule // pps_sec_timer

// >>> pps_top.sv
/*
  Pump pressure supervisor: transducer scaling and calibration, low suction
  fault, minimum on-time selection, auto sleep ramp and sleep entry, with a
  classic Wishbone register slave and a masked interrupt.
  Assumes 125 MHz clk, transducer codes arriving asynchronously as 12-bit
  codes spanning 4..20 mA, and a motor drive that follows motor_run/freq.
*/
// The placing of the registers and the Wishbone register port are this design's own decisions.
// Notes on behaviour
// - Full scale reading equals configured sensor range; the code reads one psi below it
// - Add signed measurement offset, limited to fifty
// - Analog setpoint gets signed setpoint offset added
// - Commanded frequency gets signed offset, thirty Hz
// - Flow and level readings scaled by multipliers
// - Suction fault after continuous low for time
// - Only second input compared to fault level
// - Previous off time selects short or long
// - Auto sleep allowed only inside setpoint band
// - Auto sleep after band held detection time
// - Sleep ramp rate set by curve value
// - Sleep entered after fixed six second delay
`timescale 1ns/100ps
`include "pps_consts.svh"

module pps_top
  import pps_pkg::*;
#(
  parameter int TICK_CYCLES = `PPS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Transducer codes, asynchronous
  input  wire logic [11:0] ai1_code,
  input  wire logic [11:0] ai2_code,
  // Motor commands and status
  output logic             motor_run,
  output logic      [15:0] motor_freq,
  output logic             low_suction_fault,
  output logic             auto_sleep,
  output logic             irq
);

  typedef struct packed {
    logic [11:0] ai1_m;
    logic [11:0] ai1;
    logic [11:0] ai2_m;
    logic [11:0] ai2;
    logic [26:0] div;
    logic        tick;
    pps_ctrl_t   ctrl;
    pps_range_t  range;
    pps_offs_t   offs;
    pps_setp_t   setp;
    pps_scale_t  scale;
    pps_suct_t   suct;
    pps_cycle_t  cycle;
    pps_ontime_t ontime;
    pps_sleep_t  sleep;
    pps_curve_t  curve;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mask;
    pps_fsm_t    fsm;
    logic [13:0] on_lim;
    logic [15:0] freq;
    logic        fault;
    logic        ack;
    logic [31:0] rdat;
  } pps_state_t;

  pps_state_t s;
  pps_state_t next_s;

  // Byte-lane merge for a masked register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel, input logic [31:0] m);
    logic [31:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & m;
    merge = (old & ~lanes) | (d & lanes);
  endfunction

  // Unsigned clamp into a range
  function automatic logic [13:0] clampu(input logic [13:0] v, input logic [13:0] lo,
                                         input logic [13:0] hi);
    clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Signed clamp to +/- lim
  function automatic logic signed [7:0] clamps(input logic signed [7:0] v,
                                               input logic [7:0] lim);
    logic signed [7:0] l;
    l = $signed(lim);
    clamps = (v > l) ? l : ((v < -l) ? -l : v);
  endfunction

  // Code span maps onto 0..full scale, so 20 mA (code 4095) reads one psi below the sensor range
  function automatic logic [8:0] to_psi(input logic [11:0] code, input logic [8:0] span);
    logic [20:0] prod;
    prod = code * span;
    to_psi = prod[20:`PPS_ADC_SHIFT];
  endfunction

  // Decimal multiplier in hundredths: 0.01, 0.1, 1
  function automatic logic [15:0] mul_factor(input logic [1:0] sel);
    case (sel)
      2'h0:    mul_factor = 16'h0001;
      2'h1:    mul_factor = 16'h000a;
      default: mul_factor = 16'h0064;
    endcase
  endfunction

  // Measured values and effective setpoint
  logic signed [11:0] meas;
  logic signed [11:0] suct_meas;
  logic signed [11:0] sp_eff;
  logic signed [11:0] diff;
  logic [11:0]        abs_diff;
  logic               in_band;
  logic signed [8:0]  f_sum;
  logic [15:0]        f_cmd;
  logic [15:0]        f_floor;
  logic [15:0]        meas_pos;

  assign meas      = $signed({3'h0, to_psi(s.ai1, s.range.span)})
                   + 12'(s.offs.meas_off);
  assign suct_meas = $signed({3'h0, to_psi(s.ai2, s.range.span)})
                   + 12'(s.offs.meas_off);
  assign sp_eff    = s.ctrl.role_sel
                   ? $signed({3'h0, to_psi(s.ai2, s.range.span)}) + 12'(s.offs.sp_off)
                   : $signed({2'h0, s.setp.setpoint});
  assign diff      = meas - sp_eff;
  assign abs_diff  = diff[11] ? 12'(-diff) : 12'(diff);
  // Half-width is band tenths-of-percent of setpoint; negative setpoint never in band
  assign in_band   = !sp_eff[11]
                   && (22'(abs_diff) * `PPS_BAND_SCALE
                       <= 22'(sp_eff) * 22'(s.sleep.band));
  assign f_sum     = $signed({2'h0, s.setp.freq_cmd}) + 9'(s.offs.freq_off);
  assign f_cmd     = f_sum[8] ? 16'h0000 : 16'(f_sum) * `PPS_HZ_UNITS;
  assign f_floor   = 16'({1'b0, s.curve.min_freq} + 8'(s.curve.sleep_freq))
                   * `PPS_HZ_UNITS;
  assign meas_pos  = meas[11] ? 16'h0000 : 16'(meas);

  // Duration timers
  logic [13:0] off_cnt;
  logic        suct_done;
  logic        on_met;
  logic        det_done;
  logic        dly_done;

  pps_sec_timer #(.W(14)) u_suct (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (s.tick),
    .qualify (suct_meas < $signed({4'h0, s.suct.low_level})),
    .limit   (14'(s.suct.suct_time)),
    .count   (),
    .done    (suct_done)
  );

  pps_sec_timer #(.W(14)) u_off (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (s.tick),
    .qualify (s.fsm == PPS_STOP),
    .limit   (14'h0000),
    .count   (off_cnt),
    .done    ()
  );

  pps_sec_timer #(.W(14)) u_on (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (s.tick),
    .qualify (s.fsm != PPS_STOP),
    .limit   (s.on_lim),
    .count   (),
    .done    (on_met)
  );

  pps_sec_timer #(.W(14)) u_det (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (s.tick),
    .qualify (s.fsm == PPS_RUN && in_band),
    .limit   (14'(s.sleep.detect)),
    .count   (),
    .done    (det_done)
  );

  pps_sec_timer #(.W(14)) u_dly (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (s.tick),
    .qualify (s.fsm == PPS_HOLD && in_band && on_met),
    .limit   (`PPS_SLEEP_DELAY_S),
    .count   (),
    .done    (dly_done)
  );

  // Register read mux, from current state only
  logic [31:0] rd_mux;
  pps_stat_t   stat;
  pps_rdg_t    rdg;

  always_comb begin
    stat      = '0;
    stat.fsm  = s.fsm;
    stat.fault = s.fault;
    stat.run  = s.fsm != PPS_STOP;
    stat.sp   = sp_eff;
    stat.meas = meas;
    rdg.flow  = 16'(meas_pos * mul_factor(s.scale.flow_mul));
    rdg.level = 16'(meas_pos * mul_factor(s.scale.level_mul));
    case (wb_adr_i[5:2])
      `PPS_A_CTRL:   rd_mux = s.ctrl;
      `PPS_A_RANGE:  rd_mux = s.range;
      `PPS_A_OFFS:   rd_mux = s.offs;
      `PPS_A_SETP:   rd_mux = s.setp;
      `PPS_A_SCALE:  rd_mux = s.scale;
      `PPS_A_SUCT:   rd_mux = s.suct;
      `PPS_A_CYCLE:  rd_mux = s.cycle;
      `PPS_A_ONTIME: rd_mux = s.ontime;
      `PPS_A_SLEEP:  rd_mux = s.sleep;
      `PPS_A_CURVE:  rd_mux = s.curve;
      `PPS_A_STAT:   rd_mux = stat;
      `PPS_A_IRQ:    rd_mux = 32'(s.irq_st);
      `PPS_A_MASK:   rd_mux = 32'(s.irq_mask);
      `PPS_A_FREQ:   rd_mux = 32'(s.freq);
      `PPS_A_RDG:    rd_mux = rdg;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Next state: synchronisers, time base, bus, registers and motor sequence
  logic        wr;
  logic [3:0]  ev;
  logic [3:0]  w1c;

  always_comb begin
    next_s = s;
    ev     = 4'h0;
    w1c    = 4'h0;
    // Two flops before any logic sees the transducer codes
    next_s.ai1_m = ai1_code;
    next_s.ai1   = s.ai1_m;
    next_s.ai2_m = ai2_code;
    next_s.ai2   = s.ai2_m;
    // One-second enable from the system clock
    next_s.tick = 1'b0;
    if (s.div == 27'(TICK_CYCLES - 1)) begin
      next_s.div  = 27'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 27'h1;
    end
    // Ack one cycle after the request, data latched with it
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (next_s.ack) begin
      next_s.rdat = rd_mux;
    end
    wr = s.ack && wb_cyc_i && wb_stb_i && wb_we_i;
    if (wr) begin
      case (wb_adr_i[5:2])
        `PPS_A_CTRL: next_s.ctrl = merge(s.ctrl, wb_dat_i, wb_sel_i, `PPS_M_CTRL);
        `PPS_A_RANGE: begin
          next_s.range = merge(s.range, wb_dat_i, wb_sel_i, `PPS_M_RANGE);
          next_s.range.span = 9'(clampu(14'(next_s.range.span), `PPS_RANGE_MIN,
                                        `PPS_RANGE_MAX));
        end
        `PPS_A_OFFS: begin
          next_s.offs = merge(s.offs, wb_dat_i, wb_sel_i, `PPS_M_OFFS);
          next_s.offs.meas_off = clamps(next_s.offs.meas_off, `PPS_OFFS_LIM);
          next_s.offs.sp_off   = clamps(next_s.offs.sp_off, `PPS_OFFS_LIM);
          next_s.offs.freq_off = clamps(next_s.offs.freq_off, `PPS_FOFF_LIM);
        end
        `PPS_A_SETP:  next_s.setp = merge(s.setp, wb_dat_i, wb_sel_i, `PPS_M_SETP);
        `PPS_A_SCALE: next_s.scale = merge(s.scale, wb_dat_i, wb_sel_i, `PPS_M_SCALE);
        `PPS_A_SUCT: begin
          next_s.suct = merge(s.suct, wb_dat_i, wb_sel_i, `PPS_M_SUCT);
          next_s.suct.suct_time = 11'(clampu(14'(next_s.suct.suct_time), 14'h0,
                                             `PPS_SUCT_MAX));
          next_s.suct.low_level = 8'(clampu(14'(next_s.suct.low_level), 14'h0,
                                            `PPS_LOW_MAX));
        end
        `PPS_A_CYCLE: begin
          next_s.cycle = merge(s.cycle, wb_dat_i, wb_sel_i, `PPS_M_CYCLE);
          next_s.cycle.off_time_threshold = clampu(next_s.cycle.off_time_threshold,
                                                   14'h0, `PPS_OFF_TIME_THRESHOLD_MAX);
        end
        `PPS_A_ONTIME: begin
          // Ordering short < long is software's duty; only the range is held here
          next_s.ontime = merge(s.ontime, wb_dat_i, wb_sel_i, `PPS_M_ONTIME);
          next_s.ontime.short_min_on_time = 10'(clampu(14'(next_s.ontime.short_min_on_time),
                                                       14'h0, `PPS_ON_MAX));
          next_s.ontime.long_min_on_time = 10'(clampu(14'(next_s.ontime.long_min_on_time),
                                                      14'h0, `PPS_ON_MAX));
        end
        `PPS_A_SLEEP: begin
          next_s.sleep = merge(s.sleep, wb_dat_i, wb_sel_i, `PPS_M_SLEEP);
          next_s.sleep.band = 10'(clampu(14'(next_s.sleep.band), 14'h0, `PPS_BAND_MAX));
          next_s.sleep.detect = 9'(clampu(14'(next_s.sleep.detect), `PPS_DET_MIN,
                                          `PPS_DET_MAX));
        end
        `PPS_A_CURVE: begin
          next_s.curve = merge(s.curve, wb_dat_i, wb_sel_i, `PPS_M_CURVE);
          next_s.curve.curve = 10'(clampu(14'(next_s.curve.curve), `PPS_CURVE_MIN,
                                          `PPS_CURVE_MAX));
        end
        `PPS_A_IRQ:  w1c = wb_dat_i[3:0] & {4{wb_sel_i[0]}};
        `PPS_A_MASK: begin
          if (wb_sel_i[0]) begin
            next_s.irq_mask = wb_dat_i[3:0] & `PPS_M_IRQ;
          end
        end
        default: ;
      endcase
    end
    // Motor sequence; a suction fault stops the motor from any state
    next_s.fault = suct_done;
    ev[0] = suct_done && !s.fault;
    if (s.fault) begin
      next_s.fsm  = PPS_STOP;
      next_s.freq = 16'h0000;
    end else begin
      case (s.fsm)
        PPS_STOP: begin
          next_s.freq = 16'h0000;
          if (s.ctrl.run_en && meas < sp_eff) begin
            next_s.fsm    = PPS_RUN;
            next_s.freq   = f_cmd;
            next_s.on_lim = (off_cnt > s.cycle.off_time_threshold)
                          ? 14'(s.ontime.short_min_on_time)
                          : 14'(s.ontime.long_min_on_time);
            ev[3] = 1'b1;
          end
        end
        PPS_RUN: begin
          next_s.freq = f_cmd;
          if (!s.ctrl.run_en) begin
            next_s.fsm = PPS_STOP;
          end else if (det_done) begin
            next_s.fsm = PPS_RAMP;
            ev[1] = 1'b1;
          end
        end
        PPS_RAMP: begin
          if (!s.ctrl.run_en || !in_band) begin
            next_s.fsm = s.ctrl.run_en ? PPS_RUN : PPS_STOP;
          end else if (s.tick) begin
            // Step down by the curve value each second until the sleep floor
            if (s.freq > f_floor + 16'(s.curve.curve)) begin
              next_s.freq = s.freq - 16'(s.curve.curve);
            end else begin
              // Never step up to the floor when the command already sits below it
              next_s.freq = (s.freq < f_floor) ? s.freq : f_floor;
              next_s.fsm  = PPS_HOLD;
            end
          end
        end
        PPS_HOLD: begin
          next_s.freq = (s.freq < f_floor) ? s.freq : f_floor;
          if (!s.ctrl.run_en || !in_band) begin
            next_s.fsm = s.ctrl.run_en ? PPS_RUN : PPS_STOP;
          end else if (dly_done) begin
            next_s.fsm = PPS_STOP;
            ev[2] = 1'b1;
          end
        end
        default: next_s.fsm = PPS_STOP;
      endcase
    end
    // Sticky events; a new event wins over a clear in the same cycle
    next_s.irq_st = (s.irq_st & ~w1c) | ev;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s        <= '0;
      s.ctrl   <= `PPS_RST_CTRL;
      s.range  <= `PPS_RST_RANGE;
      s.offs   <= `PPS_RST_OFFS;
      s.setp   <= `PPS_RST_SETP;
      s.scale  <= `PPS_RST_SCALE;
      s.suct   <= `PPS_RST_SUCT;
      s.cycle  <= `PPS_RST_CYCLE;
      s.ontime <= `PPS_RST_ONTIME;
      s.sleep  <= `PPS_RST_SLEEP;
      s.curve  <= `PPS_RST_CURVE;
      s.fsm    <= PPS_STOP;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign wb_dat_o          = s.rdat;
  assign wb_ack_o          = s.ack;
  assign motor_run         = s.fsm != PPS_STOP;
  assign motor_freq        = s.freq;
  assign low_suction_fault = s.fault;
  assign auto_sleep        = s.fsm == PPS_RAMP || s.fsm == PPS_HOLD;
  assign irq               = |(s.irq_st & s.irq_mask);

endmodule // pps_top

// >>> pps_top_assertions.sv
/*
  Checker for pps_top ports.
  Assumes one clock, synchronous active low reset.
*/
`timescale 1ns/100ps
module pps_top_assertions #(
  parameter int TICK_CYCLES = 10
) (
  // Clock, reset, bus, outputs
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        motor_run,
  input wire logic [15:0] motor_freq,
  input wire logic        low_suction_fault,
  input wire logic        auto_sleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bus handshake
  chk_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  chk_dat_hold:
    assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("dat moved");
  // Motor state relations
  chk_sleep_run:
    assert property (auto_sleep |-> motor_run) else $error("sleep without run");
  chk_ramp_down:
    assert property (auto_sleep && $past(auto_sleep) |-> motor_freq <= $past(motor_freq)) else $error("ramp up");
  chk_fault_stop:
    assert property ($rose(low_suction_fault) |-> ##[0:2] !motor_run) else $error("run on fault");
  chk_start_clean:
    assert property ($rose(motor_run) |-> !$past(low_suction_fault)) else $error("start in fault");
  chk_stop_freq:
    assert property ($fell(motor_run) |-> ##[0:2] motor_freq == 16'h0000) else $error("freq after stop");
  // Main scenarios reached
  cover property ($rose(auto_sleep));
  cover property ($rose(low_suction_fault));
  cover property ($fell(motor_run));
endmodule // pps_top_assertions
bind pps_top pps_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) pps_top_assertions_i (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .motor_run(motor_run),
  .motor_freq(motor_freq), .low_suction_fault(low_suction_fault), .auto_sleep(auto_sleep));

// >>> pps_xdcr.sv
/*
  Transducer model for the pump pressure supervisor bench.
  Assumes a linear 4..20 mA loop, SPAN psi at full scale.
*/
`timescale 1ns/100ps
module pps_xdcr #(
  parameter int SPAN = 256
) (
  // Pressures in psi
  input  wire logic [9:0]  psi1,
  input  wire logic [9:0]  psi2,
  // Loop codes
  output logic      [11:0] code1,
  output logic      [11:0] code2
);
  // Zero psi at 4 mA; the code saturates like a real loop
  function automatic logic [11:0] cv(input logic [9:0] p);
    int c;
    c = p * 4096 / SPAN;
    return (c > 4095) ? 12'hfff : c[11:0];
  endfunction
  // Both loops use the same span
  assign code1 = cv(psi1);
  assign code2 = cv(psi2);
endmodule // pps_xdcr

// >>> tb_top.sv
/*
  Self-checking bench for pps_top.
  Assumes a ten cycle tick and a 256 psi transducer.
*/
`timescale 1ns/100ps
`include "pps_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam int TK = 10;
  logic        clk, rst_n, cyc, stb, we, ack, run, flt, slp, irq;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dato, rdat;
  logic [11:0] c1, c2;
  logic [15:0] frq;
  logic [9:0]  p1, p2;
  int          failures = 0;
  int          n_checks = 0;
  pps_xdcr #(.SPAN(256)) pps_xdcr_i (.psi1(p1), .psi2(p2), .code1(c1), .code2(c2));
  pps_top #(.TICK_CYCLES(TK)) pps_top_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .ai1_code(c1), .ai2_code(c2), .motor_run(run), .motor_freq(frq), .low_suction_fault(flt),
    .auto_sleep(slp), .irq(irq));
  // Classic cycle: hold until ack, then idle one cycle
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    int k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= v;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) failures++;
    rdat = dato;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat & m, e)
  endtask
  // Wait for a level with a bound, return cycles spent
  task automatic wt(input int n, output int k);
    k = 0;
    while (k < n && !(flt | slp)) begin @(posedge clk); k++; end
  endtask
  // Reset values, clamping, unmapped word
  task automatic t_regs;
    rchk(6'h04, 32'hffffffff, `PPS_RST_RANGE);
    rchk(6'h14, 32'hffffffff, `PPS_RST_SUCT);
    rchk(6'h1c, 32'hffffffff, `PPS_RST_ONTIME);
    rchk(6'h24, 32'hffffffff, `PPS_RST_CURVE);
    rchk(6'h3c, 32'hffffffff, 32'h0);
    bus(1'b1, 6'h04, 32'h1ff);
    rchk(6'h04, 32'h1ff, 32'h1f4);
    bus(1'b1, 6'h04, 32'h10);
    rchk(6'h04, 32'h1ff, 32'h32);
    bus(1'b1, 6'h08, 32'h00e2_7f81);
    rchk(6'h08, 32'hffffff, 32'he2_32ce);
    bus(1'b1, 6'h04, 32'h100);
  endtask
  // Offset, scaling and setpoint source
  task automatic t_meas;
    bus(1'b1, 6'h08, 32'h0000_0505);
    repeat (8) @(posedge clk);
    rchk(6'h28, 32'hfff, 32'd45);
    rchk(6'h28, 32'hfff000, 32'd50 << 12);
    rchk(6'h38, 32'hffffffff, {16'd45, 16'd450});
    bus(1'b1, 6'h10, 32'h8);
    rchk(6'h38, 32'hffffffff, {16'd4500, 16'd45});
    bus(1'b1, 6'h00, 32'h2);
    repeat (8) @(posedge clk);
    rchk(6'h28, 32'hfff000, 32'd45 << 12);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b1, 6'h08, 32'h0);
  endtask
  // Suction fault timing, mask and clear
  task automatic t_suct;
    int k;
    bus(1'b1, 6'h2c, 32'hf);
    bus(1'b1, 6'h30, 32'h1);
    `CHK(irq, 1'b0)
    bus(1'b1, 6'h14, 32'h7803);
    p1 <= 10'd5;
    repeat (5 * TK) @(posedge clk);
    `CHK(flt, 1'b0)
    p1 <= 10'd40;
    p2 <= 10'd10;
    repeat (2 * TK - 2) @(posedge clk);
    `CHK(flt, 1'b0)
    wt(TK + 12, k);
    `CHK(flt, 1'b1)
    `CHK(irq, 1'b1)
    bus(1'b1, 6'h30, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, 6'h30, 32'h1);
    p2 <= 10'd40;
    repeat (4) @(posedge clk);
    `CHK(flt, 1'b0)
    bus(1'b1, 6'h2c, 32'h1);
    `CHK(irq, 1'b0)
  endtask
  // Start, band, ramp and sleep
  task automatic t_cycle;
    int k;
    bus(1'b1, 6'h1c, 32'h001e_0001);
    bus(1'b1, 6'h18, 32'h0);
    bus(1'b1, 6'h24, 32'h0f1c_03e7);
    bus(1'b1, 6'h08, 32'h0003_0000);
    p1 <= 10'd30;
    bus(1'b1, 6'h00, 32'h1);
    repeat (4) @(posedge clk);
    `CHK(run, 1'b1)
    `CHK(frq, 16'd6300)
    p1 <= 10'd52;
    repeat (5 * TK) @(posedge clk);
    `CHK(slp, 1'b0)
    p1 <= 10'd50;
    repeat (2 * TK - 2) @(posedge clk);
    `CHK(slp, 1'b0)
    wt(TK + 12, k);
    `CHK(slp, 1'b1)
    wt(2 * TK + 4, k);
    while (frq === 16'd6300 && k < 3 * TK) begin @(posedge clk); k++; end
    `CHK(frq, 16'd5301)
    k = 0;
    while (run === 1'b1 && k < 40 * TK) begin @(posedge clk); k++; end
    `CHK(run, 1'b0)
    `CHK(k > 7 * TK, 1'b1)
    `CHK(k < 10 * TK, 1'b1)
  endtask
  task automatic conclude;
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    #(8 * TK * 2000);
    failures++;
    conclude();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 6'h0; sel = 4'hf; wdat = 32'h0;
    p1 = 10'd40; p2 = 10'd40;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_meas();
    t_suct();
    t_cycle();
    conclude();
  end
endmodule // tb_top
